//--- common/adsc_pkg.sv
// ==========================================================
// Constants for the converter sequencing block
// ==========================================================
package adsc_pkg;

    // ======================================================
    // Clocking and sequence timing
    // ======================================================
    localparam int CLK_HZ          = 40_000_000;
    localparam int E_CLK_HZ        = 2_000_000;
    localparam int RC_CLK_HZ       = 2_000_000;  // Internal oscillator rate, plain default
    localparam int E_DIV           = CLK_HZ / E_CLK_HZ;
    localparam int RC_DIV          = CLK_HZ / RC_CLK_HZ;
    localparam int DIV_W           = 5;
    localparam int SEQ_E_CYCLES    = 128;
    localparam int SLOTS           = 4;
    localparam int SLOT_E_CYCLES   = SEQ_E_CYCLES / SLOTS;
    localparam int SAMPLE_E_CYCLES = 12;
    localparam int CNT_W           = 5;

    // ======================================================
    // Register map (byte addresses) and reset values
    // ======================================================
    localparam logic [7:0] ADDR_CTL  = 8'h00;
    localparam logic [7:0] ADDR_RES1 = 8'h04;
    localparam logic [7:0] ADDR_RES2 = 8'h08;
    localparam logic [7:0] ADDR_RES3 = 8'h0C;
    localparam logic [7:0] ADDR_RES4 = 8'h10;
    localparam logic [7:0] ADDR_OPT  = 8'h14;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET = 8'h00;

    // ======================================================
    // Field positions
    // ======================================================
    localparam int CTL_DONE_BIT   = 7;
    localparam int CTL_ZERO_BIT   = 6;
    localparam int CTL_SCAN_BIT   = 5;
    localparam int CTL_GROUP_BIT  = 4;
    localparam int OPT_POWER_BIT  = 7;
    localparam int OPT_CLKSRC_BIT = 6;
    localparam int OPT_DELAY_BIT  = 4;

    // ======================================================
    // Bus responses and sequencer states
    // ======================================================
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        ADSC_IDLE    = 2'b00,
        ADSC_START   = 2'b01,
        ADSC_CONVERT = 2'b10,
        ADSC_SUSPEND = 2'b11
    } adsc_state_t;

endpackage : adsc_pkg

//--- hdl/adsc_result_mem.sv
`timescale 1ns/10ps
// ==========================================================
// Four result slots, one write port, registered read
// ==========================================================
module adsc_result_mem (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       we,
    input  wire logic [1:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [1:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] slot_mem [0:3];

    // Slot storage, cleared by reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                slot_mem[i] <= 8'h00;
            end
        end else if (we) begin
            slot_mem[waddr] <= wdata;
        end
    end

    // Registered read keeps the bus path short
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= slot_mem[raddr];
        end
    end
endmodule : adsc_result_mem

//--- hdl/adsc_seq.sv
`timescale 1ns/10ps
// ==========================================================
// Converter sequencer with register slave
// ==========================================================
// Notes on behaviour
// - Single channel, one-shot: four conversions into slots one to four, then halt.
// - Single channel, continuous: keep converting, wrapping back to slot one.
// - Group, one-shot: each of four group channels once into slots, then halt.
// - Group, continuous: cycle the group forever, each result to its own slot.
// - Stop or wait suspends the conversion; resume resamples that channel.
// - Control bit 7 read-only status, bit 6 reads zero, others read/write.
// - Any control write while powered starts a sequence, aborting any running one.
// - Done flag sets when all four slots valid; control write clears it.
// - In continuous mode done flag sets after first four and stays set.
// - Group bit clear: low nibble picks the single channel converted.
// - Group bit set: top two select bits pick the four-channel group.
// - Channel codes 0-7 inputs, 12-14 references, others reserved.
// - Group mode stores each result in slot given by code low bits.
// - Four read-only 8-bit result registers; writes leave them unchanged.
// - Group continuous resamples each channel once per 128 E cycles.
// - Sequence begins one E cycle after the control write.
// - Converter runs only while power bit 7 of option register is set.
// - Clock source bit picks E clock when zero, internal clock when one.
module adsc_seq
    import adsc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cpu_stop,
    input  wire logic        cpu_wait,
    input  wire logic [7:0]  conv_result,
    output logic [3:0]       conv_channel,
    output logic             conv_sampling,
    output logic             conv_active,
    output logic             converter_power_on,
    output logic             conv_clock_source
);
    import adsc_pkg::*;

    // ======================================================
    // Declarations
    // ======================================================
    logic [7:0]  aw_addr;
    logic        aw_have;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        w_have;
    logic        do_write;
    logic        ctl_write;
    logic [7:0]  ar_addr;
    logic        rd_pend;
    logic [7:0]  mem_rdata;
    logic [5:0]  ctl_bits;
    logic        sequence_done_flag;
    logic [7:0]  opt_bits;
    logic        pause_meta;
    logic        pause_sync;
    logic [7:0]  res_meta;
    logic [7:0]  res_sync;
    logic [DIV_W-1:0] div_cnt;
    logic        e_tick;
    adsc_state_t state;
    logic [CNT_W-1:0] e_cnt;
    logic [1:0]  slot_idx;
    logic        slot_end;
    logic        store_en;
    logic [3:0]  next_channel;

    // ======================================================
    // Write channel: address and data taken in either order
    // ======================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have       <= 1'b0;
            aw_addr       <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have       <= 1'b0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have       <= 1'b1;
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_have <= 1'b0;
        end else if (!w_have && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Both halves present and no response pending
    assign do_write  = aw_have && w_have && !s_axi_bvalid;
    assign ctl_write = do_write && w_lane0 && (aw_addr == ADDR_CTL);

    // Write response; result slots answer OKAY but keep data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if ((aw_addr == ADDR_CTL) || (aw_addr == ADDR_OPT) ||
                (aw_addr == ADDR_RES1) || (aw_addr == ADDR_RES2) ||
                (aw_addr == ADDR_RES3) || (aw_addr == ADDR_RES4)) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_DECERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ======================================================
    // Control and option registers
    // ======================================================
    // Only bits 5:0 are stored; bit 7 is hardware status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_bits <= CTL_RESET[5:0];
        end else if (ctl_write) begin
            ctl_bits <= w_byte[5:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opt_bits <= OPT_RESET;
        end else if (do_write && w_lane0 && (aw_addr == ADDR_OPT)) begin
            opt_bits <= w_byte;
        end
    end

    // Option bits drive the analog side through one register stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_power_on <= 1'b0;
            conv_clock_source  <= 1'b0;
        end else begin
            converter_power_on <= opt_bits[OPT_POWER_BIT];
            conv_clock_source  <= opt_bits[OPT_CLKSRC_BIT];
        end
    end

    // ======================================================
    // Read channel: one address, data two edges later
    // ======================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            ar_addr       <= 8'h00;
            rd_pend       <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            ar_addr       <= s_axi_araddr;
            rd_pend       <= 1'b1;
        end else if (rd_pend) begin
            rd_pend <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Memory read data settles one edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_pend) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (ar_addr)
                ADDR_CTL:  s_axi_rdata <= {24'h000000, sequence_done_flag,
                                           1'b0, ctl_bits};
                ADDR_RES1,
                ADDR_RES2,
                ADDR_RES3,
                ADDR_RES4: s_axi_rdata <= {24'h000000, mem_rdata};
                ADDR_OPT:  s_axi_rdata <= {24'h000000, opt_bits};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ======================================================
    // Synchronisers for pins from outside this clock
    // ======================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_meta <= 1'b0;
            pause_sync <= 1'b0;
            res_meta   <= 8'h00;
            res_sync   <= 8'h00;
        end else begin
            pause_meta <= cpu_stop | cpu_wait;
            pause_sync <= pause_meta;
            res_meta   <= conv_result;
            res_sync   <= res_meta;
        end
    end

    // ======================================================
    // Converter clock divider
    // ======================================================
    // Either source becomes a tick; the internal oscillator
    // is modelled as a rate, not a second clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= '0;
            e_tick  <= 1'b0;
        end else if ((!conv_clock_source && div_cnt == DIV_W'(E_DIV - 1)) ||
                     (conv_clock_source && div_cnt == DIV_W'(RC_DIV - 1))) begin
            div_cnt <= '0;
            e_tick  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            e_tick  <= 1'b0;
        end
    end

    // ======================================================
    // Sequencer
    // ======================================================
    assign slot_end = e_tick && (e_cnt == CNT_W'(SLOT_E_CYCLES - 1));
    assign store_en = (state == ADSC_CONVERT) && slot_end && !pause_sync;

    // A control write wins unless power is off, and restarts from slot one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ADSC_IDLE;
            e_cnt    <= '0;
            slot_idx <= 2'h0;
        end else if (!converter_power_on) begin
            state    <= ADSC_IDLE;
            e_cnt    <= '0;
            slot_idx <= 2'h0;
        end else if (ctl_write) begin
            state    <= ADSC_START;
            e_cnt    <= '0;
            slot_idx <= 2'h0;
        end else begin
            case (state)
                ADSC_IDLE: begin
                    e_cnt <= '0;
                end
                ADSC_START: begin
                    if (e_tick) begin
                        state <= ADSC_CONVERT;
                    end
                end
                ADSC_CONVERT: begin
                    if (pause_sync) begin
                        state <= ADSC_SUSPEND;
                        e_cnt <= '0;
                    end else if (slot_end) begin
                        e_cnt    <= '0;
                        slot_idx <= slot_idx + 1'b1;
                        if (slot_idx == 2'h3 && !ctl_bits[CTL_SCAN_BIT]) begin
                            state <= ADSC_IDLE;
                        end
                    end else if (e_tick) begin
                        e_cnt <= e_cnt + 1'b1;
                    end
                end
                ADSC_SUSPEND: begin
                    // Same slot restarts, so the channel is resampled
                    e_cnt <= '0;
                    if (!pause_sync) begin
                        state <= ADSC_CONVERT;
                    end
                end
                default: begin
                    state <= ADSC_IDLE;
                end
            endcase
        end
    end

    // Channel code for the current slot
    always_comb begin
        if (ctl_bits[CTL_GROUP_BIT]) begin
            next_channel = {ctl_bits[3:2], slot_idx};
        end else begin
            next_channel = ctl_bits[3:0];
        end
    end

    // Mux select and sample window toward the analog side;
    // every code, reserved ones included, is driven as is
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_channel  <= 4'h0;
            conv_sampling <= 1'b0;
            conv_active   <= 1'b0;
        end else begin
            conv_channel  <= next_channel;
            conv_sampling <= (state == ADSC_CONVERT) && !pause_sync &&
                             (e_cnt < CNT_W'(SAMPLE_E_CYCLES));
            conv_active   <= (state == ADSC_CONVERT) || (state == ADSC_START);
        end
    end

    // Done flag: a completing store wins over a clearing write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sequence_done_flag <= 1'b0;
        end else if (store_en && slot_idx == 2'h3) begin
            sequence_done_flag <= 1'b1;
        end else if (ctl_write) begin
            sequence_done_flag <= 1'b0;
        end
    end

    // ======================================================
    // Result storage
    // ======================================================
    // Slot index equals code low bits in group mode
    adsc_result_mem u_result_mem (
        .clk    (aclk),
        .resetn (aresetn),
        .we     (store_en),
        .waddr  (slot_idx),
        .wdata  (res_sync),
        .raddr  (s_axi_araddr[3:2] - 2'h1),
        .rdata  (mem_rdata)
    );

endmodule : adsc_seq

//--- tb/adsc_seq_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the converter sequencer
// ==========================================================
module adsc_seq_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cpu_stop,
    input wire logic        cpu_wait,
    input wire logic [3:0]  conv_channel,
    input wire logic        conv_sampling,
    input wire logic        conv_active,
    input wire logic        converter_power_on
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ======================================================
    // Sequencer
    // ======================================================
    start_after_write_a: assert property ($rose(conv_active) |-> ##[0:20] conv_sampling)
        else $error("sampling did not follow a start");
    channel_steady_a: assert property (conv_sampling && $past(conv_sampling) |->
        $stable(conv_channel)) else $error("channel moved while sampling");
    power_gates_a: assert property (!converter_power_on [*3] |-> !conv_active)
        else $error("active while powered down");
    sample_needs_active_a: assert property (conv_sampling |-> conv_active)
        else $error("sampling outside a conversion");
    // Sync delay of the low-power inputs is allowed for
    suspend_halts_a: assert property ((cpu_stop || cpu_wait) [*5] |-> !conv_sampling)
        else $error("sampling during suspend");

    // ======================================================
    // Register bus
    // ======================================================
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read response not two cycles after address");
    write_refuse_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_awready)
        else $error("write address ready too soon");
    read_refuse_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_arready)
        else $error("read address ready too soon");
endmodule : adsc_seq_monitor

//--- tb/adsc_seq_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the converter sequencer
// ==========================================================
module adsc_seq_tb;
    import adsc_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cpu_stop, cpu_wait;
    logic        conv_sampling, conv_active, pwr, csrc, grp, prev, act, pend;
    logic [1:0]  bresp, rresp, resp, pi;
    logic [3:0]  wstrb, conv_channel;
    logic [7:0]  awaddr, araddr, conv_result, pv, c;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  exp_slot [4];
    logic [7:0]  tbl [4] = '{8'h47, 8'h1D, 8'h0A, 8'h10};
    int          fails, n_compared, cnt, cyc;
    int          last_t [16];
    int          per [16];

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    adsc_seq adsc_seq_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .conv_result(conv_result),
        .conv_channel(conv_channel), .conv_sampling(conv_sampling),
        .conv_active(conv_active), .converter_power_on(pwr), .conv_clock_source(csrc)
    );

    // ======================================================
    // Shared tasks
    // ======================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Judged at the falling edge so the taking edge never races the design
    task automatic axi(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tr, fin;
        int   n;
        fin = 1'b0;
        n = 0;
        @(posedge aclk);
        if (wr) begin
            awaddr  <= a;
            wdata   <= {24'h000000, d};
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end else begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        while (!fin && n < 200) begin
            @(negedge aclk);
            n++;
            ta = awready === 1'b1;
            tw = wready === 1'b1;
            tr = arready === 1'b1;
            fin = (wr ? bvalid : rvalid) === 1'b1;
            resp = wr ? bresp : rresp;
            q = rdata;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (fin) bready <= 1'b0;
            if (fin) rready <= 1'b0;
        end
        if (!fin) fails++;
    endtask : axi

    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        axi(1'b0, a, 8'h00);
        check(q, {24'h000000, want});
        check(32'(resp), 32'(a > ADDR_OPT ? RESP_DECERR : RESP_OKAY));
    endtask : rdchk

    task automatic chk_slots;
        for (int k = 0; k < SLOTS; k++) begin
            rdchk(ADDR_RES1 + 8'(4 * k), exp_slot[k]);
        end
    endtask : chk_slots

    task automatic wait_done;
        q = 32'h0;
        for (int n = 0; n < 1000 && q[7] !== 1'b1; n++) begin
            axi(1'b0, ADDR_CTL, 8'h00);
        end
    endtask : wait_done

    // ======================================================
    // Analog side: new value each sample, committed when the slot ends
    // ======================================================
    always begin : watch
        logic rise;
        @(negedge aclk);
        rise = conv_sampling === 1'b1 && !prev;
        if (pend && (rise || (act && conv_active !== 1'b1))) begin
            exp_slot[pi] = pv;
            pend = 1'b0;
        end
        act = conv_active === 1'b1;
        prev = conv_sampling === 1'b1;
        if (rise) begin
            pv = 8'($urandom);
            pi = grp ? conv_channel[1:0] : 2'(cnt);
            if (last_t[conv_channel] != 0) per[conv_channel] = cyc - last_t[conv_channel];
            last_t[conv_channel] = cyc;
            cnt++;
            pend = 1'b1;
            @(posedge aclk);
            conv_result <= pv;
        end
    end

    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {cpu_stop, cpu_wait, grp, prev, act, pend} = 6'h00;
        {awaddr, araddr, conv_result, wdata} = 56'h0;
        wstrb = 4'hF;
        foreach (exp_slot[k]) exp_slot[k] = 8'h00;
        void'($urandom(22));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int k = 0; k < 7; k++) begin
            rdchk(8'(4 * k), 8'h00);
        end
        axi(1'b1, 8'h18, 8'h55);
        check(32'(resp), 32'(RESP_DECERR));
        axi(1'b1, ADDR_OPT, 8'hD0);
        rdchk(ADDR_OPT, 8'hD0);
        @(negedge aclk);
        check(32'({pwr, csrc}), 32'h3);
        $display("test registers done");
        // One-shot runs, first one aborted in mid-sequence
        for (int i = 0; i < 6; i++) begin
            c = i < 4 ? tbl[i] : 8'($urandom) & 8'hDF;
            grp = c[4];
            cnt = 0;
            axi(1'b1, ADDR_CTL, c);
            if (i == 0) begin
                repeat (1000) @(posedge aclk);
                cnt = 0;
                axi(1'b1, ADDR_CTL, c);
            end
            repeat (100) @(negedge aclk);
            check(32'(conv_channel), 32'(c[4] ? {c[3:2], 2'b00} : c[3:0]));
            rdchk(ADDR_CTL, c & 8'h3F);
            wait_done;
            check(q, 32'((c & 8'h3F) | 8'h80));
            @(negedge aclk);
            check(32'(conv_active), 32'h0);
            axi(1'b1, ADDR_RES2, 8'h5A);
            check(32'(resp), 32'(RESP_OKAY));
            chk_slots;
            $display("test oneshot %0d done", i);
        end
        // Stop, then wait, in the middle of the second slot
        for (int s = 0; s < 2; s++) begin
            grp = 1'b1;
            cnt = 0;
            axi(1'b1, ADDR_CTL, 8'h14);
            repeat (1000) @(posedge aclk);
            cpu_stop <= (s == 0);
            cpu_wait <= (s == 1);
            repeat (300) @(negedge aclk);
            check(32'({conv_active, conv_sampling}), 32'h0);
            @(posedge aclk);
            cpu_stop <= 1'b0;
            cpu_wait <= 1'b0;
            wait_done;
            check(32'(cnt), 32'h5);
            chk_slots;
            $display("test suspend %0d done", s);
        end
        // Continuous group, then continuous single channel
        axi(1'b1, ADDR_OPT, 8'h80);
        cnt = 0;
        axi(1'b1, ADDR_CTL, 8'h35);
        wait_done;
        repeat (2700) @(negedge aclk);
        check(32'(conv_active), 32'h1);
        check(32'(per[5]), 32'(SEQ_E_CYCLES * E_DIV));
        rdchk(ADDR_CTL, 8'hB5);
        chk_slots;
        grp = 1'b0;
        cnt = 0;
        axi(1'b1, ADDR_CTL, 8'h23);
        wait_done;
        repeat (700) @(negedge aclk);
        check(32'(cnt), 32'h6);
        chk_slots;
        axi(1'b1, ADDR_CTL, 8'h23);
        rdchk(ADDR_CTL, 8'h23);
        $display("test continuous done");
        // Power removed: writes must not start anything
        axi(1'b1, ADDR_OPT, 8'h00);
        repeat (5) @(negedge aclk);
        check(32'({pwr, csrc}), 32'h0);
        axi(1'b1, ADDR_CTL, 8'h01);
        repeat (100) @(negedge aclk);
        check(32'(conv_active), 32'h0);
        $display("test power done");
        report_and_stop;
    end

    // Roughly twice the expected run
    initial begin
        repeat (60000) @(posedge aclk);
        fails++;
        report_and_stop;
    end
endmodule : adsc_seq_tb

bind adsc_seq adsc_seq_monitor adsc_seq_monitor_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .cpu_stop, .cpu_wait, .conv_channel, .conv_sampling,
    .conv_active, .converter_power_on
);
